// >>> design/pwm_defs.svh
// offsets, field positions, reset values and time-base counts of the pwm channel
// assumes byte addressing on a 32-bit register bus, one register per word
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

// register byte offsets
`define OFS_CHANNEL_CONTROL 6'h00
`define OFS_DUTY_UPPER 6'h04
`define OFS_DUTY_LOWER 6'h08
`define OFS_PERIOD 6'h0C
`define OFS_TIMER_CONTROL 6'h10
`define OFS_FLAGS 6'h14
`define OFS_TIMER_COUNT 6'h18
`define OFS_PIN_DIRECTION 6'h1C
`define OFS_PORT_LATCH 6'h20

// channel_control fields
`define CTL_ENABLE_BIT 7
`define CTL_OE_BIT 6
`define CTL_OUT_BIT 5
`define CTL_POL_BIT 4
// duty_lower_bits field
`define DUTY_LO_MSB 7
`define DUTY_LO_LSB 6
// period_timer_control fields
`define TCTL_RUN_BIT 2
`define TCTL_PS_MSB 1
`define TCTL_PS_LSB 0
// peripheral_flags field
`define FLAG_MATCH_BIT 0

// reset values
`define CTL_RST 8'h00
`define DUTY_RST 8'h00
`define PERIOD_RST 8'hFF
`define TCTL_RST 3'h0
`define PIN_DIR_RST 1'b1
`define PORT_LATCH_RST 1'b0

// time base: four prescaled system clocks per timer count
`define SUBSTEP_LAST 2'h3
// prescale ratio minus one for each prescale_select code
`define PS_DIV1_M1 6'h00
`define PS_DIV4_M1 6'h03
`define PS_DIV16_M1 6'h0F
`define PS_DIV64_M1 6'h3F

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> design/pwm_pkg.sv
// types shared by the pwm channel and its period timer
// assumes pwm_defs.svh for numeric constants
package pwm_pkg;

  // period timer settings as software writes them
  typedef struct packed {
    logic timer_run;
    logic [1:0] prescale_select;
  } timer_cfg_t;

  // ten-bit time base: timer count with two prescaled clock bits below
  typedef struct packed {
    logic [7:0] period_timer_count;
    logic [1:0] substep;
  } time_base_t;

  // channel control fields that steer the output
  typedef struct packed {
    logic channel_enable;
    logic pin_output_enable;
    logic polarity_select;
  } chan_ctl_t;

endpackage

// >>> design/period_timer.sv
// shared period timer: prescaler, two-bit substep and eight-bit count
// assumes one clock, synchronous active-low reset, sleep as a level input
`timescale 1ns/1ps
`include "pwm_defs.svh"
module period_timer #(
  parameter int PS_W = 6
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings
  input wire pwm_pkg::timer_cfg_t cfg,
  input wire logic [7:0] period,
  input wire logic sleep,
  // time base and period match
  output pwm_pkg::time_base_t tb_q,
  output logic wrap_q
);
  import pwm_pkg::*;

  logic [PS_W-1:0] pre_q;
  logic [PS_W-1:0] ratio_m1;
  logic counting;
  logic tick;
  logic sub_last;
  logic at_period;

  // prescale ratio decode
  assign ratio_m1 = (cfg.prescale_select == 2'h0) ? `PS_DIV1_M1 :
                    (cfg.prescale_select == 2'h1) ? `PS_DIV4_M1 :
                    (cfg.prescale_select == 2'h2) ? `PS_DIV16_M1 : `PS_DIV64_M1;
  assign counting = cfg.timer_run & ~sleep;
  assign tick = counting & (pre_q == ratio_m1);
  assign sub_last = tb_q.substep == `SUBSTEP_LAST;
  assign at_period = tb_q.period_timer_count == period;

  // prescaler, then four substeps per count; count clears on period match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= '0;
      tb_q <= '0;
      wrap_q <= 1'b0;
    end else begin
      wrap_q <= tick & sub_last & at_period;
      if (counting) begin
        pre_q <= tick ? '0 : pre_q + 1'b1;
      end
      if (tick) begin
        tb_q.substep <= tb_q.substep + 1'b1;
        if (sub_last) begin
          tb_q.period_timer_count <= at_period ? 8'h00 : tb_q.period_timer_count + 8'h01;
        end
      end
    end
  end

endmodule // period_timer

// >>> design/ten_bit_pwm_channel.sv
// ten-bit pwm channel with its period timer and an axi4-lite register slave
// assumes one 10 MHz clock, synchronous active-low reset, sleep as a level
//
// How it works
// - output resolution is ten bits, one ten-bit compare value per channel
// - period comes from the shared timer and period register; duty is per channel
// - output goes active when the timer count clears
// - output goes inactive when time base equals buffered ten-bit duty
// - duty at or beyond the full period keeps output active all period
// - duty registers are copied to the buffer only at period match
// - after period match: count clears, output activates, duty latches; zero stays off
// - polarity select inverts the output level
// - period is (period register + 1) times four clocks times prescale
// - duty is upper eight bits plus lower register bits 7:6, writable anytime
// - time base is timer count plus two prescaled clock bits
// - no postscaler affects the output
// - resolution is log2 of 4*(period+1), ten bits at period 255
// - sleep stops the count and holds channel state and pin level
// - reset makes the pin an input and resets all registers
// - output shares the pin with the port latch; output enable selects
// - polarity set means active low, clear means active high
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pwm_defs.svh"
module ten_bit_pwm_channel #(
  parameter int ADDR_W = 6
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // power state
  input wire logic sleep,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // pin and internal output
  output logic pin_out,
  output logic pin_oe,
  output logic output_value
);
  import pwm_pkg::*;

  // software-visible state
  chan_ctl_t ctl_q;
  logic [7:0] duty_upper_bits_q;
  logic [1:0] duty_lower_bits_q;
  logic [7:0] period_register_q;
  timer_cfg_t tcfg_q;
  logic timer_match_flag_q;
  logic pin_direction_q;
  logic port_latch_q;

  // channel state
  logic [9:0] duty_buf_q;
  logic active_q;
  time_base_t tb;
  logic wrap;

  // bus state
  logic aw_hold_q;
  logic w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic lane0_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // output flops
  logic pin_out_q;
  logic pin_oe_q;
  logic output_value_q;

  // shared period timer
  period_timer #(
    .PS_W(6)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(tcfg_q),
    .period(period_register_q),
    .sleep(sleep),
    .tb_q(tb),
    .wrap_q(wrap)
  );

  // write channel handshakes
  logic aw_fire;
  logic w_fire;
  logic do_write;
  logic b_fire;
  logic aw_hold_d;
  logic w_hold_d;
  logic bvalid_d;
  assign aw_fire = awvalid & awready_q;
  assign w_fire = wvalid & wready_q;
  assign do_write = aw_hold_q & w_hold_q;
  assign b_fire = bvalid_q & bready;
  assign aw_hold_d = (aw_hold_q | aw_fire) & ~do_write;
  assign w_hold_d = (w_hold_q | w_fire) & ~do_write;
  assign bvalid_d = do_write | (bvalid_q & ~bready);

  // write address decode
  logic [ADDR_W-1:0] wa;
  logic wr_ctl;
  logic wr_dhi;
  logic wr_dlo;
  logic wr_per;
  logic wr_tctl;
  logic wr_flag;
  logic wr_cnt;
  logic wr_dir;
  logic wr_lat;
  logic wr_hit;
  logic wr_en;
  assign wa = {awaddr_q[ADDR_W-1:2], 2'b00};
  assign wr_ctl = wa == `OFS_CHANNEL_CONTROL;
  assign wr_dhi = wa == `OFS_DUTY_UPPER;
  assign wr_dlo = wa == `OFS_DUTY_LOWER;
  assign wr_per = wa == `OFS_PERIOD;
  assign wr_tctl = wa == `OFS_TIMER_CONTROL;
  assign wr_flag = wa == `OFS_FLAGS;
  assign wr_cnt = wa == `OFS_TIMER_COUNT;
  assign wr_dir = wa == `OFS_PIN_DIRECTION;
  assign wr_lat = wa == `OFS_PORT_LATCH;
  assign wr_hit = wr_ctl | wr_dhi | wr_dlo | wr_per | wr_tctl | wr_flag | wr_cnt | wr_dir
                  | wr_lat;
  assign wr_en = do_write & lane0_q;

  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      lane0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready_q <= ~aw_hold_d & ~bvalid_d;
      wready_q <= ~w_hold_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (aw_fire) begin
        awaddr_q <= awaddr;
      end
      if (w_fire) begin
        wdata_q <= wdata;
        lane0_q <= wstrb[0];
      end
      if (do_write) begin
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // software registers; all return to reset values on any reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= '0;
      duty_upper_bits_q <= `DUTY_RST;
      duty_lower_bits_q <= 2'h0;
      period_register_q <= `PERIOD_RST;
      tcfg_q <= `TCTL_RST;
      pin_direction_q <= `PIN_DIR_RST;
      port_latch_q <= `PORT_LATCH_RST;
    end else if (wr_en) begin
      if (wr_ctl) begin
        ctl_q.channel_enable <= wdata_q[`CTL_ENABLE_BIT];
        ctl_q.pin_output_enable <= wdata_q[`CTL_OE_BIT];
        ctl_q.polarity_select <= wdata_q[`CTL_POL_BIT];
      end
      if (wr_dhi) begin
        duty_upper_bits_q <= wdata_q[7:0];
      end
      if (wr_dlo) begin
        duty_lower_bits_q <= wdata_q[`DUTY_LO_MSB:`DUTY_LO_LSB];
      end
      if (wr_per) begin
        period_register_q <= wdata_q[7:0];
      end
      if (wr_tctl) begin
        tcfg_q.timer_run <= wdata_q[`TCTL_RUN_BIT];
        tcfg_q.prescale_select <= wdata_q[`TCTL_PS_MSB:`TCTL_PS_LSB];
      end
      if (wr_dir) begin
        pin_direction_q <= wdata_q[0];
      end
      if (wr_lat) begin
        port_latch_q <= wdata_q[0];
      end
    end
  end

  // match flag: set by period match, cleared by writing one; set wins
  logic flag_clr;
  assign flag_clr = wr_en & wr_flag & wdata_q[`FLAG_MATCH_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_match_flag_q <= 1'b0;
    end else if (wrap) begin
      timer_match_flag_q <= 1'b1;
    end else if (flag_clr) begin
      timer_match_flag_q <= 1'b0;
    end
  end

  // read channel handshakes
  logic ar_fire;
  logic rvalid_d;
  assign ar_fire = arvalid & arready_q;
  assign rvalid_d = ar_fire | (rvalid_q & ~rready);

  // read address decode and data select
  logic [ADDR_W-1:0] ra;
  logic [7:0] rd_byte;
  logic rd_hit;
  assign ra = {araddr[ADDR_W-1:2], 2'b00};
  assign rd_hit = (ra == `OFS_CHANNEL_CONTROL) | (ra == `OFS_DUTY_UPPER)
                  | (ra == `OFS_DUTY_LOWER) | (ra == `OFS_PERIOD)
                  | (ra == `OFS_TIMER_CONTROL) | (ra == `OFS_FLAGS)
                  | (ra == `OFS_TIMER_COUNT) | (ra == `OFS_PIN_DIRECTION)
                  | (ra == `OFS_PORT_LATCH);
  assign rd_byte =
    (ra == `OFS_CHANNEL_CONTROL) ? {ctl_q.channel_enable, ctl_q.pin_output_enable,
                                    output_value_q, ctl_q.polarity_select, 4'h0} :
    (ra == `OFS_DUTY_UPPER) ? duty_upper_bits_q :
    (ra == `OFS_DUTY_LOWER) ? {duty_lower_bits_q, 6'h00} :
    (ra == `OFS_PERIOD) ? period_register_q :
    (ra == `OFS_TIMER_CONTROL) ? {5'h00, tcfg_q} :
    (ra == `OFS_FLAGS) ? {7'h00, timer_match_flag_q} :
    (ra == `OFS_TIMER_COUNT) ? tb.period_timer_count :
    (ra == `OFS_PIN_DIRECTION) ? {7'h00, pin_direction_q} :
    (ra == `OFS_PORT_LATCH) ? {7'h00, port_latch_q} : 8'h00;

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_fire) begin
        rdata_q <= {24'h000000, rd_byte};
        rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ten-bit duty as written and compare against the ten-bit time base
  logic [9:0] duty_val;
  logic [9:0] period_end;
  logic full_on;
  logic at_duty;
  assign duty_val = {duty_upper_bits_q, duty_lower_bits_q};
  assign period_end = {period_register_q, `SUBSTEP_LAST};
  assign full_on = duty_buf_q > period_end;
  assign at_duty = tb == duty_buf_q;

  // channel latch: set at period start, cleared at duty match
  logic active_d;
  always_comb begin
    active_d = active_q;
    if (!ctl_q.channel_enable) begin
      active_d = 1'b0;
    end else if (sleep) begin
      active_d = active_q;
    end else if (wrap) begin
      active_d = duty_val != 10'h000;
    end else if (at_duty && !full_on) begin
      active_d = 1'b0;
    end
  end

  // polarity and pin multiplexing
  logic output_value_d;
  logic pin_out_d;
  assign output_value_d = active_d ^ ctl_q.polarity_select;
  assign pin_out_d = ctl_q.pin_output_enable ? output_value_d : port_latch_q;

  // duty buffer, channel state and output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_buf_q <= '0;
      active_q <= 1'b0;
      output_value_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      if (wrap) begin
        duty_buf_q <= duty_val;
      end
      active_q <= active_d;
      if (!sleep) begin
        output_value_q <= output_value_d;
        pin_out_q <= pin_out_d;
      end
      pin_oe_q <= ~pin_direction_q;
    end
  end

  // outputs straight from flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign output_value = output_value_q;

endmodule // ten_bit_pwm_channel

// >>> test/pwm_channel_props.sv
// port checker of the pwm channel
// assumes a bind onto ten_bit_pwm_channel, one clock domain
`timescale 1ns/1ps
module pwm_channel_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // power state
  input wire logic sleep,
  // register bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // pin and internal output
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic output_value
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // outputs leave reset cleared, pin released
  property p_reset_clear;
    $rose(aresetn) |-> !pin_oe && !pin_out && !output_value && !bvalid && !rvalid;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
  // write answer stands until taken
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  // read answer stands until taken
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  // write answer two edges after address and data
  property p_b_answer;
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  // read answer next cycle, no new address meanwhile
  property p_r_answer;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  // registers are eight bits wide
  property p_upper_zero;
    rvalid |-> rdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read upper bits set");
  // only okay or slave error
  property p_bresp_code;
    bvalid |-> bresp == 2'h0 || bresp == 2'h2;
  endproperty
  a_bresp_code: assert property (p_bresp_code) else $error("bad write response");
  // no new write while an answer waits
  property p_aw_block;
    bvalid |-> !awready && !wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during answer");
  // sleep freezes output and pin
  property p_sleep_hold;
    sleep && $past(sleep) |=> $stable(output_value) && $stable(pin_out);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("output moved in sleep");
endmodule // pwm_channel_props

// >>> test/pwm_pin_load.sv
// load on the modulated pin with a pull-down
// assumes pin_oe high while the channel drives the pin
`timescale 1ns/1ps
module pwm_pin_load (
  // pin from the channel
  input wire logic pin_out,
  input wire logic pin_oe,
  // level the load sees
  output logic level
);
  // undriven pin falls to the pull-down level
  assign level = pin_oe ? pin_out : 1'b0;
endmodule // pwm_pin_load

// >>> test/test_ten_bit_pwm_channel.sv
// self-checking bench of the pwm channel through its register bus
// assumes design/ on the include path, 10 MHz clock
`timescale 1ns/1ps
`include "pwm_defs.svh"
module test_ten_bit_pwm_channel;
  logic aclk, aresetn, sleep, awvalid, wvalid, bready, arvalid, rready, level;
  logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, output_value;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [1:0] bresp, rresp, rd_resp, wr_resp;
  int n_errors = 0;
  int checks_done = 0;
  // design and pin load
  ten_bit_pwm_channel DUT (.aclk, .aresetn, .sleep, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .pin_out, .pin_oe, .output_value);
  pwm_pin_load u_load (.pin_out, .pin_oe, .level);
  // 100 ns clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // an expired wait ends the run
  task automatic hang(string what);
    check(what, 32'h0, 32'h1);
    complete_run;
  endtask
  // one register write, both channels offered together; late holds bready low that long
  task automatic wr(logic [5:0] a, logic [7:0] d, int late = 0);
    bit aw, w, b, br;
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    br = (late == 0);
    bready <= br;
    for (i = 0; i < 100 && !b; i++) begin
      @(posedge aclk);
      if (awready && !aw) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wready && !w) begin
        w = 1;
        wvalid <= 1'b0;
      end
      if (bvalid && br) begin
        b = 1;
        wr_resp = bresp;
        bready <= 1'b0;
      end
      if (i + 1 == late) begin
        br = 1'b1;
        bready <= 1'b1;
      end
    end
    if (!b) hang("write wait");
  endtask
  // one register read; late holds rready low that many cycles
  task automatic rd(logic [5:0] a, int late = 0);
    int i;
    bit rr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rr = (late == 0);
    rready <= rr;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rr) begin
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
        return;
      end
      if (i + 1 == late) begin
        rr = 1'b1;
        rready <= 1'b1;
      end
    end
    hang("read wait");
  endtask
  // length of the current run of output level v
  task automatic level_run(logic v, output int n);
    n = 0;
    while (output_value === v && n < 3000) begin
      @(negedge aclk);
      n++;
    end
  endtask
  task automatic wait_rise;
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge aclk);
      if (output_value === 1'b0) break;
    end
    for (i = 0; i < 3000; i++) begin
      @(negedge aclk);
      if (output_value === 1'b1) return;
    end
    hang("rise wait");
  endtask
  // start-up order for a clean first period, period register 1
  task automatic setup(logic [1:0] ps, logic [9:0] duty, logic [7:0] ctl, logic dir);
    int i;
    wr(`OFS_PIN_DIRECTION, 8'h01);
    wr(`OFS_CHANNEL_CONTROL, 8'h00);
    wr(`OFS_PERIOD, 8'h01);
    wr(`OFS_DUTY_UPPER, 8'h00);
    wr(`OFS_DUTY_LOWER, 8'h00);
    wr(`OFS_FLAGS, 8'h01);
    wr(`OFS_TIMER_CONTROL, {6'h01, ps});
    rd_data = 32'h0;
    for (i = 0; i < 400 && !rd_data[0]; i++) rd(`OFS_FLAGS);
    check("match flag", rd_data[0], 1'b1);
    wr(`OFS_DUTY_UPPER, duty[9:2]);
    wr(`OFS_DUTY_LOWER, {duty[1:0], 6'h00});
    wr(`OFS_PIN_DIRECTION, {7'h00, dir});
    wr(`OFS_CHANNEL_CONTROL, ctl);
  endtask
  task automatic t_reset;
    logic [5:0] ofs [9] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20};
    logic [7:0] rst [9] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    int i;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("pin enable", pin_oe, 1'b0);
    for (i = 0; i < 9; i++) begin
      rd(ofs[i], i % 4);
      check("reset value", rd_data, {24'h000000, rst[i]});
    end
    rd(6'h24);
    check("unmapped read", {rd_resp, rd_data[29:0]}, {`RESP_SLVERR, 30'h0});
    wr(6'h24, 8'h5A, 4);
    check("unmapped write", wr_resp, `RESP_SLVERR);
    $display("reset test done");
  endtask
  // all prescale codes, internal use only, pin left off
  task automatic t_wave;
    int ps, h, l, r;
    for (ps = 0; ps < 4; ps++) begin
      r = 1 << (2 * ps);
      setup(ps[1:0], 10'd3, 8'h80, 1'b1);
      wait_rise;
      level_run(1'b1, h);
      level_run(1'b0, l);
      check("high time", h, 3 * r);
      check("period", h + l, 8 * r);
    end
    $display("waveform test done");
  endtask
  task automatic t_edges;
    int h;
    setup(2'h0, 10'd8, 8'h80, 1'b1);
    repeat (10) @(negedge aclk);
    level_run(1'b1, h);
    check("full on", h, 3000);
    wr(`OFS_DUTY_UPPER, 8'h00);
    repeat (10) @(negedge aclk);
    level_run(1'b0, h);
    check("zero duty", h, 3000);
    $display("duty limits test done");
  endtask
  task automatic t_polarity;
    int h, l;
    setup(2'h0, 10'd3, 8'h90, 1'b1);
    wait_rise;
    level_run(1'b1, h);
    level_run(1'b0, l);
    check("inverted high", h, 5);
    check("active low time", l, 3);
    $display("polarity test done");
  endtask
  // duty written mid-period waits for the next match
  task automatic t_buffer;
    int h;
    setup(2'h3, 10'd3, 8'h80, 1'b1);
    wait_rise;
    fork
      level_run(1'b1, h);
      begin
        wr(`OFS_DUTY_UPPER, 8'h00);
        wr(`OFS_DUTY_LOWER, 8'h40);
      end
    join
    check("old duty", h, 192);
    wait_rise;
    level_run(1'b1, h);
    check("new duty", h, 64);
    $display("buffer test done");
  endtask
  task automatic t_sleep;
    logic v;
    logic [31:0] c;
    int h;
    wait_rise;
    @(posedge aclk);
    sleep <= 1'b1;
    repeat (3) @(posedge aclk);
    v = output_value;
    rd(`OFS_TIMER_COUNT);
    c = rd_data;
    repeat (300) @(posedge aclk);
    rd(`OFS_TIMER_COUNT);
    check("count in sleep", rd_data, c);
    check("level in sleep", output_value, v);
    @(posedge aclk);
    sleep <= 1'b0;
    wait_rise;
    level_run(1'b1, h);
    check("after wake", h, 64);
    $display("sleep test done");
  endtask
  task automatic t_pin;
    setup(2'h0, 10'd0, 8'h00, 1'b0);
    wr(`OFS_PORT_LATCH, 8'h01);
    repeat (3) @(negedge aclk);
    check("pin driven", pin_oe, 1'b1);
    check("latch on pin", level, 1'b1);
    wr(`OFS_CHANNEL_CONTROL, 8'hC0);
    repeat (12) @(negedge aclk);
    check("pwm on pin", level, 1'b0);
    check("pin follows pwm", pin_out, output_value);
    wr(`OFS_PIN_DIRECTION, 8'h01);
    repeat (3) @(negedge aclk);
    check("released pin", {pin_oe, level}, 2'b00);
    $display("pin test done");
  endtask
  // main sequence, ending with a reset in mid-run
  initial begin
    aresetn = 1'b0;
    sleep = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h0;
    t_reset;
    t_wave;
    t_edges;
    t_polarity;
    t_buffer;
    t_sleep;
    t_pin;
    t_reset;
    complete_run;
  end
endmodule // test_ten_bit_pwm_channel
bind ten_bit_pwm_channel pwm_channel_props u_props (.aclk, .aresetn, .sleep, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .pin_out, .pin_oe, .output_value);
